// *** hw/chan_irq_defs.svh ***
// address map, field positions and reset values for the channel irq block
`ifndef CHAN_IRQ_DEFS_SVH
`define CHAN_IRQ_DEFS_SVH
`define ADDR_W        8
`define DATA_W        8
`define EVT_W         4
`define NUM_CHAN      12
`define ENABLE_LO     4'h1
`define STATUS_LO     4'h2
`define HALF_CHANS    6
`define UPPER_BASE    4'h8
`define RSV_ZERO      4'h0
`define ENABLE_RST    4'h0
`define STATUS_RST    4'h0
`define BIT_FIFO      3
`define BIT_LOCK      2
`define BIT_SIG       1
`define BIT_DRIVE     0
`endif

// *** hw/chan_irq_pkg.sv ***
// types shared by the channel irq block
`include "chan_irq_defs.svh"
package chan_irq_pkg;
	typedef logic [`EVT_W-1:0] evt_t;
	typedef struct packed {
		evt_t [`NUM_CHAN-1:0] enable;
		evt_t [`NUM_CHAN-1:0] status;
		evt_t [`NUM_CHAN-1:0] cond;
		evt_t [`NUM_CHAN-1:0] sync1;
		evt_t [`NUM_CHAN-1:0] sync2;
		logic [`DATA_W-1:0]   rdata;
	} state_t;
endpackage : chan_irq_pkg

// *** hw/chan_source_irq_enable_status.sv ***
// per-channel change-of-condition interrupt enable and status registers
//
// Operation
// - enable register at channel nibble, low nibble one
// - enable bit 3 flags fifo limit changes
// - enable bit 2 flags lock-lost changes
// - enable bit 1 flags signal-lost changes
// - enable bit 0 flags drive monitor changes
// - enable bits read and write, one enables
// - status bits 3..0 events, 7..4 reserved
// - status flag sets on event, clears on read
// - channel summary holds until status read
`timescale 1ns/1ps
`include "chan_irq_defs.svh"
module chan_source_irq_enable_status
	import chan_irq_pkg::*;
#(
	parameter int NCH = `NUM_CHAN
) (
	input  wire logic                  CLK_I,
	input  wire logic                  RST_N_I,
	input  wire logic [`ADDR_W-1:0]    ADDR_I,
	input  wire logic [`DATA_W-1:0]    WDATA_I,
	input  wire logic                  WR_I,
	input  wire logic                  RD_I,
	input  wire logic [NCH-1:0]        FIFO_LIMIT_ALARM_I,
	input  wire logic [NCH-1:0]        RECEIVE_LOCK_LOST_I,
	input  wire logic [NCH-1:0]        RECEIVE_SIGNAL_LOST_I,
	input  wire logic [NCH-1:0]        DRIVE_MONITOR_OUT_I,
	output logic      [`DATA_W-1:0]    RDATA_O,
	output logic      [NCH-1:0]        CHAN_PENDING_O,
	output logic                       IRQ_O
);

	state_t q;
	state_t d;
	evt_t   raw   [NCH];
	evt_t   chg   [NCH];
	logic   [NCH-1:0] hit_en;
	logic   [NCH-1:0] hit_st;
	logic   [NCH-1:0] irq_src;

	// every check samples on the rising clock and rests during reset
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RST_N_I);

	// ------------------------------------------------------------
	// address decode and condition inputs per channel
	// ------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			localparam logic [3:0] HI = (g < `HALF_CHANS) ?
				4'(g) : 4'(`UPPER_BASE + g - `HALF_CHANS);
			assign hit_en[g] = (ADDR_I == {HI, `ENABLE_LO});
			assign hit_st[g] = (ADDR_I == {HI, `STATUS_LO});
			// pack pins so each lands on its status bit
			assign raw[g] = {FIFO_LIMIT_ALARM_I[g], RECEIVE_LOCK_LOST_I[g],
				RECEIVE_SIGNAL_LOST_I[g], DRIVE_MONITOR_OUT_I[g]};
			// an edge of a synchronised condition is a change only where its enable bit is set
			assign chg[g] = (q.sync2[g] ^ q.cond[g]) & q.enable[g];
		end
	endgenerate

	// ------------------------------------------------------------
	// next state: sync, enables, sticky status, read data
	// ------------------------------------------------------------
	always_comb begin
		d = q;
		d.rdata = '0;
		for (int c = 0; c < NCH; c++) begin
			d.sync1[c] = raw[c];
			d.sync2[c] = q.sync1[c];
			d.cond[c]  = q.sync2[c];
			if (WR_I && hit_en[c]) begin
				d.enable[c] = WDATA_I[`EVT_W-1:0];
			end
			if (RD_I && hit_en[c]) begin
				d.rdata = {`RSV_ZERO, q.enable[c]};
			end
			if (RD_I && hit_st[c]) begin
				d.rdata = {`RSV_ZERO, q.status[c]};
				d.status[c] = chg[c]; // event in read cycle wins
			end else begin
				d.status[c] = q.status[c] | chg[c];
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign RDATA_O = q.rdata;
	generate
		for (g = 0; g < NCH; g++) begin : g_sum
			// summary stays until that channel's status is read,
			// even when its enable bits are dropped meanwhile
			assign CHAN_PENDING_O[g] = |q.status[g];
			// request counts only flags whose enable is still set
			assign irq_src[g] = |(q.status[g] & q.enable[g]);
		end
	endgenerate
	assign IRQ_O = |irq_src;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// status read of channel 0 with no fresh change in that cycle
	sequence s_read_ch0;
		RD_I && hit_st[0] && chg[0] == '0;
	endsequence

	// fresh change of any enabled event on channel 0
	sequence s_event_ch0;
		chg[0] != '0;
	endsequence

	// pin rises, bit still enabled when the sync chain shows the edge
	sequence s_drive_rise;
		$rose(DRIVE_MONITOR_OUT_I[0]) ##2 q.enable[0][`BIT_DRIVE];
	endsequence

	// channel 0 summary is up and its status is not being read
	sequence s_pending_unread;
		CHAN_PENDING_O[0] && !(RD_I && hit_st[0]);
	endsequence

	// status flags: clear on read, sticky otherwise, writes ignored
	chk_status_clear_read: assert property (
		s_read_ch0 |=> q.status[0] == '0)
		else $error("status not cleared by read");

	chk_status_sticky: assert property (
		q.status[0][`BIT_FIFO] && !(RD_I && hit_st[0])
		|=> q.status[0][`BIT_FIFO])
		else $error("fifo limit flag lost without read");

	chk_status_no_write: assert property (
		WR_I && hit_st[0] && !RD_I && chg[0] == '0
		|=> $stable(q.status[0]))
		else $error("status changed by a write");

	// read data: status, enables, reserved bits, idle and unmapped
	chk_read_returns_status: assert property (
		RD_I && hit_st[0]
		|=> RDATA_O == {`RSV_ZERO, $past(q.status[0])})
		else $error("status read data wrong");

	chk_reserved_zero: assert property (
		RDATA_O[`DATA_W-1:`EVT_W] == `RSV_ZERO)
		else $error("reserved read bits not zero");

	chk_rdata_idle: assert property (
		!RD_I |=> RDATA_O == '0)
		else $error("read data left standing");

	chk_unmapped_read: assert property (
		RD_I && ADDR_I == 8'h71 |=> RDATA_O == '0)
		else $error("unmapped read not zero");

	chk_enable_read: assert property (
		RD_I && hit_en[2] |=> RDATA_O == {`RSV_ZERO, $past(q.enable[2])})
		else $error("enable read data wrong");

	// enable bits: written value lands, otherwise held
	chk_enable_write_read: assert property (
		WR_I && hit_en[1] |=> q.enable[1] == $past(WDATA_I[`EVT_W-1:0]))
		else $error("enable write lost");

	chk_enable_hold: assert property (
		!(WR_I && hit_en[1]) |=> $stable(q.enable[1]))
		else $error("enable changed without write");

	// change detection per event bit
	chk_fifo_edge_flag: assert property (
		chg[0][`BIT_FIFO] |=> q.status[0][`BIT_FIFO])
		else $error("fifo limit change not flagged");

	chk_lock_edge_flag: assert property (
		$changed(q.cond[0][`BIT_LOCK]) && $past(q.enable[0][`BIT_LOCK])
		&& $past(RST_N_I) |-> q.status[0][`BIT_LOCK])
		else $error("lock change not flagged");

	chk_sig_disabled: assert property (
		!q.enable[0][`BIT_SIG] && !q.status[0][`BIT_SIG]
		|=> !q.status[0][`BIT_SIG])
		else $error("disabled signal-lost flagged");

	chk_drive_pin_flag: assert property (
		s_drive_rise |=> q.status[0][`BIT_DRIVE])
		else $error("drive monitor change not flagged");

	// channel summary and interrupt request
	chk_pending_hold: assert property (
		s_pending_unread |=> CHAN_PENDING_O[0])
		else $error("summary dropped without read");

	chk_pending_on_event: assert property (
		s_event_ch0 |=> CHAN_PENDING_O[0])
		else $error("summary not raised by event");

	chk_pending_clear: assert property (
		s_read_ch0 |=> !CHAN_PENDING_O[0])
		else $error("summary not cleared by read");

	chk_irq_any: assert property (
		(|(q.status[NCH-1] & q.enable[NCH-1])) |-> IRQ_O)
		else $error("irq request missing");

	chk_irq_source: assert property (
		IRQ_O |-> (|CHAN_PENDING_O))
		else $error("irq request without a flag");

	// channel nibble decode across the gap
	chk_decode_chan6: assert property (
		ADDR_I == 8'h81 |-> hit_en[6])
		else $error("channel six decode wrong");

	chk_decode_last: assert property (
		ADDR_I == 8'hD1 |-> hit_en[NCH-1])
		else $error("last channel decode wrong");

endmodule : chan_source_irq_enable_status

// *** dv/chan_source_irq_enable_status_bench.sv ***
// self-checking bench for the channel irq enable and status block
`timescale 1ns/1ps
`include "chan_irq_defs.svh"
module chan_source_irq_enable_status_bench;
	logic        clk = 0;
	logic        rst_n = 0;
	logic [7:0]  addr = 0;
	logic [7:0]  wdata = 0;
	logic        wr = 0;
	logic        rd = 0;
	logic [11:0] cnd [4] = '{default: '0};
	logic [7:0]  rdata;
	logic [11:0] pend;
	logic        irq;
	int          n_errors = 0;
	int          check_count = 0;
	int          e;
	// 25 MHz clock
	always #20 clk = ~clk;
	chan_source_irq_enable_status u_dut (
		.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr), .RD_I(rd), .FIFO_LIMIT_ALARM_I(cnd[3]),
		.RECEIVE_LOCK_LOST_I(cnd[2]), .RECEIVE_SIGNAL_LOST_I(cnd[1]),
		.DRIVE_MONITOR_OUT_I(cnd[0]), .RDATA_O(rdata),
		.CHAN_PENDING_O(pend), .IRQ_O(irq)
	);
	// compare and count
	task automatic chk(input string nm, input logic [11:0] s,
		input logic [11:0] x);
		check_count++;
		if (s !== x) begin
			n_errors++;
			$display("ERROR %s exp %h seen %h", nm, x, s);
		end
	endtask : chk
	// channel nibble skips 6 and 7
	function automatic logic [7:0] ra(input int ch, input logic [3:0] lo);
		return {4'(ch < 6 ? ch : ch + 2), lo};
	endfunction : ra
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1;
		@(negedge clk);
		wr = 0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] x);
		@(negedge clk);
		addr = a;
		rd = 1;
		@(negedge clk);
		rd = 0;
		chk("rdata", 12'(rdata), 12'(x));
	endtask : rd_reg
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// watchdog cuts a hang short
	initial begin
		#400000;
		n_errors++;
		tally_and_finish();
	end
	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		repeat (5) @(negedge clk);
		rst_n = 1;
		for (int ch = 0; ch < 12; ch++) begin
			rd_reg(ra(ch, `ENABLE_LO), 8'h00);
			wr_reg(ra(ch, `ENABLE_LO), {4'hF, 4'(ch ^ 5)});
			rd_reg(ra(ch, `ENABLE_LO), {4'h0, 4'(ch ^ 5)});
			wr_reg(ra(ch, `STATUS_LO), 8'hFF);
			rd_reg(ra(ch, `STATUS_LO), 8'h00);
			wr_reg(ra(ch, `ENABLE_LO), 8'h00);
		end
		rd_reg(8'h71, 8'h00);
		// each event, rising and falling, then disabled
		for (int ch = 0; ch < 12; ch++) for (int b = 0; b < 4; b++) begin
			wr_reg(ra(ch, `ENABLE_LO), 8'(1 << b));
			for (int v = 1; v >= 0; v--) begin
				cnd[b][ch] = v[0];
				repeat (5) @(negedge clk);
				chk("pending", pend, 12'(1) << ch);
				chk("irq", 12'(irq), 12'h001);
				rd_reg(ra((ch + 1) % 12, `STATUS_LO), 8'h00);
				chk("pending", pend, 12'(1) << ch);
				rd_reg(ra(ch, `STATUS_LO), 8'(1 << b));
				chk("pending", pend, 12'h000);
				chk("irq", 12'(irq), 12'h000);
				rd_reg(ra(ch, `STATUS_LO), 8'h00);
			end
			wr_reg(ra(ch, `ENABLE_LO), 8'h00);
			cnd[b][ch] = 1;
			repeat (5) @(negedge clk);
			chk("irq", 12'(irq), 12'h000);
			rd_reg(ra(ch, `STATUS_LO), 8'h00);
			cnd[b][ch] = 0;
			repeat (5) @(negedge clk);
		end
		// summary outlives a dropped enable until the status read
		wr_reg(ra(3, `ENABLE_LO), 8'h01);
		cnd[0][3] = 1;
		repeat (5) @(negedge clk);
		wr_reg(ra(3, `ENABLE_LO), 8'h00);
		chk("pending", pend, 12'h008);
		chk("irq", 12'(irq), 12'h000);
		rd_reg(ra(3, `STATUS_LO), 8'h01);
		chk("pending", pend, 12'h000);
		cnd[0][3] = 0;
		// reset in mid-run drops enables and flags
		wr_reg(ra(9, `ENABLE_LO), 8'h0F);
		cnd[1][9] = 1;
		repeat (5) @(negedge clk);
		chk("pending", pend, 12'h200);
		rst_n = 0;
		repeat (2) @(negedge clk);
		rst_n = 1;
		chk("pending", pend, 12'h000);
		rd_reg(ra(9, `ENABLE_LO), 8'h00);
		repeat (5) @(negedge clk);
		rd_reg(ra(9, `STATUS_LO), 8'h00);
		cnd[1][9] = 0;
		repeat (5) @(negedge clk);
		tally_and_finish();
	end
endmodule : chan_source_irq_enable_status_bench
